// >>> core/psta_pkg.sv
/*
 Package for the program space table access block: widths, field positions,
 operation codes and reset values.
 Assumes a 16-bit data path, 24-bit program words and an 8-bit table page.
*/
package psta_pkg;

   localparam int DATA_W = 16;
   localparam int PWORD_W = 24;
   localparam int PAGE_W = 8;
   localparam int EA_W = 16;
   localparam int PADDR_W = PAGE_W + EA_W;

   // Table page bit that picks configuration space
   localparam int PAGE_CFG_BIT = 7;
   localparam logic [PAGE_W-1:0] PAGE_RESET = 8'h00;

   // Program counter step per program word
   localparam logic [PADDR_W-1:0] PC_STEP = 24'h000002;
   localparam logic [PADDR_W-1:0] PC_RESET = 24'h000000;

   localparam int LOW_HI = 15;
   localparam int LOW_LO = 0;
   localparam int HIGH_HI = 23;
   localparam int HIGH_LO = 16;
   localparam logic [7:0] PHANTOM_BYTE = 8'h00;

   typedef enum logic [1:0]
   {
      PSTA_OP_READ_LOW = 2'b00,
      PSTA_OP_READ_HIGH = 2'b01,
      PSTA_OP_WRITE_LOW = 2'b10,
      PSTA_OP_WRITE_HIGH = 2'b11
   } psta_op_e;

   typedef enum logic [1:0]
   {
      PSTA_ST_IDLE = 2'b00,
      PSTA_ST_READ = 2'b01,
      PSTA_ST_DONE = 2'b10,
      PSTA_ST_FETCH = 2'b11
   } psta_state_e;

endpackage

// >>> core/psta_table_access.sv
/*
 Table access block: moves bytes or words between 24-bit program memory and
 the data space for the four table operations, and steps the program counter.
 Assumes a synchronous program memory array with one-cycle read latency and
 per-lane write enables, and a core that holds a request until o_done.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - The program counter advances by two for each program word so program and data addresses line up.
// - Program memory is seen as a low 16-bit word space and an upper byte space at the same addresses.
// - Low table reads and writes reach the lower program word directly, with no data space window.
// - Only the high operations touch program bits 23 to 16.
// - A low word read returns program bits 15 to 0 as data bits 15 to 0.
// - A low byte read returns the upper lower-word byte when byte select is one, else the lower byte.
// - A high word read returns program bits 23 to 16 in the low data byte with the upper byte zero.
// - A high byte read returns bits 23 to 16 for byte select zero and zero for byte select one.
// - High and low writes store single bytes or whole words just as reads fetch them.
// - Every table operation takes its program memory region from the table page register.
// - Table page bit 7 clear selects user space, set selects configuration space.
module psta_table_access
#(
   parameter int DATA_W = psta_pkg::DATA_W,
   parameter int PWORD_W = psta_pkg::PWORD_W
)
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   // Program counter stepping
   input wire logic i_pc_advance,
   input wire logic i_pc_load,
   input wire logic [psta_pkg::PADDR_W-1:0] i_pc_load_value,
   output logic [psta_pkg::PADDR_W-1:0] o_pc,
   // Table page register writes
   input wire logic i_page_write,
   input wire logic [psta_pkg::PAGE_W-1:0] i_page_data,
   output logic [psta_pkg::PAGE_W-1:0] o_table_page_reg,
   // Table operation request from the execute stage
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic i_byte_mode,
   input wire logic [psta_pkg::EA_W-1:0] i_eff_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   output logic o_busy,
   output logic o_done,
   output logic [DATA_W-1:0] o_rdata,
   // Program memory array
   output logic [psta_pkg::PADDR_W-1:0] o_pm_addr,
   output logic o_pm_cfg_space,
   output logic o_pm_read,
   output logic o_pm_write,
   output logic [2:0] o_pm_lane_we,
   output logic [PWORD_W-1:0] o_pm_wdata,
   input wire logic [PWORD_W-1:0] i_pm_rdata
);

   // ************************************************************
   // Decoding
   // ************************************************************
   // Lane enables for a write: bit 0 = P<7:0>, bit 1 = P<15:8>, bit 2 = P<23:16>
   function automatic logic [2:0] psta_lanes(input logic high, input logic byte_mode, input logic bsel);
      logic [2:0] lanes;
      lanes = 3'h0;
      // The phantom upper byte has nowhere to land: no lane, yet done still pulses
      if (high)
         lanes = (byte_mode && bsel) ? 3'h0 : 3'h4;
      else if (!byte_mode)
         lanes = 3'h3;
      else
         lanes = bsel ? 3'h2 : 3'h1;
      return lanes;
   endfunction

   psta_pkg::psta_state_e state_reg;
   psta_pkg::psta_state_e state_next;
   logic [psta_pkg::PAGE_W-1:0] page_reg;
   logic [psta_pkg::PADDR_W-1:0] pc_reg;
   logic [psta_pkg::PADDR_W-1:0] pc_next;
   logic [DATA_W-1:0] rdata_reg;
   logic [DATA_W-1:0] rdata_next;
   logic [psta_pkg::PADDR_W-1:0] addr_reg;
   logic cfg_reg;
   logic [2:0] lane_reg;
   logic [PWORD_W-1:0] wdata_reg;
   logic high_reg;
   logic byte_reg;
   logic bsel_reg;
   logic read_reg;
   logic write_reg;

   wire logic req_high = i_op[0];
   wire logic req_write = i_op[1];
   wire logic req_bsel = i_eff_addr[0];
   // Only idle takes a request; one raised while busy waits to be seen
   wire logic take = i_req && (state_reg == psta_pkg::PSTA_ST_IDLE);
   wire logic [psta_pkg::PADDR_W-1:0] req_addr = {page_reg, i_eff_addr};
   wire logic req_cfg = page_reg[psta_pkg::PAGE_CFG_BIT];
   wire logic [2:0] req_lanes = psta_lanes(req_high, i_byte_mode, req_bsel);
   // Write data lands on the lanes its read would come from
   wire logic [PWORD_W-1:0] req_wdata = req_high
      ? {i_wdata[7:0], 16'h0000}
      : (i_byte_mode ? {8'h00, i_wdata[7:0], i_wdata[7:0]} : {8'h00, i_wdata[15:0]});

   // ************************************************************
   // Read data steering
   // ************************************************************
   // Steering uses the captured request fields, since the core may already show the next one
   wire logic [15:0] low_word = i_pm_rdata[psta_pkg::LOW_HI:psta_pkg::LOW_LO];
   wire logic [7:0] high_byte = i_pm_rdata[psta_pkg::HIGH_HI:psta_pkg::HIGH_LO];
   wire logic [7:0] low_sel_byte = bsel_reg ? low_word[15:8] : low_word[7:0];
   // The upper program byte has no partner, so selecting its upper half reads zero
   wire logic [7:0] high_sel_byte = bsel_reg ? psta_pkg::PHANTOM_BYTE : high_byte;
   wire logic [15:0] steered = high_reg
      ? {psta_pkg::PHANTOM_BYTE, (byte_reg ? high_sel_byte : high_byte)}
      : (byte_reg ? {8'h00, low_sel_byte} : low_word);

   assign rdata_next = (state_reg == psta_pkg::PSTA_ST_READ) ? steered : rdata_reg;

   // ************************************************************
   // Sequencer
   // ************************************************************
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         psta_pkg::PSTA_ST_IDLE:
            if (i_req)
               state_next = req_write ? psta_pkg::PSTA_ST_DONE : psta_pkg::PSTA_ST_FETCH;
         // The array answers one cycle after its read strobe, so a read waits here first
         psta_pkg::PSTA_ST_FETCH:
            state_next = psta_pkg::PSTA_ST_READ;
         psta_pkg::PSTA_ST_READ:
            state_next = psta_pkg::PSTA_ST_DONE;
         psta_pkg::PSTA_ST_DONE:
            state_next = psta_pkg::PSTA_ST_IDLE;
         default:
            state_next = psta_pkg::PSTA_ST_IDLE;
      endcase
   end

   // ************************************************************
   // Program counter
   // ************************************************************
   // Load wins over advance so a branch target is never skipped
   assign pc_next = i_pc_load ? i_pc_load_value
      : (i_pc_advance ? pc_reg + psta_pkg::PC_STEP : pc_reg);

   // ************************************************************
   // State and page registers
   // ************************************************************
   // The program counter keeps stepping while a table access is in flight
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         state_reg <= psta_pkg::PSTA_ST_IDLE;
         page_reg <= psta_pkg::PAGE_RESET;
         pc_reg <= psta_pkg::PC_RESET;
         rdata_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         // A page write during a request counts for the next one only
         if (i_page_write)
            page_reg <= i_page_data;
         pc_reg <= pc_next;
         rdata_reg <= rdata_next;
      end
   end

   // ************************************************************
   // Request capture
   // ************************************************************
   // Strobes last one cycle; address, space and data stand until the next take
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         addr_reg <= '0;
         cfg_reg <= 1'b0;
         lane_reg <= 3'h0;
         wdata_reg <= '0;
         high_reg <= 1'b0;
         byte_reg <= 1'b0;
         bsel_reg <= 1'b0;
         read_reg <= 1'b0;
         write_reg <= 1'b0;
      end
      else
      begin
         read_reg <= take && !req_write;
         write_reg <= take && req_write;
         if (take)
         begin
            addr_reg <= req_addr;
            cfg_reg <= req_cfg;
            lane_reg <= req_write ? req_lanes : 3'h0;
            wdata_reg <= req_wdata;
            high_reg <= req_high;
            byte_reg <= i_byte_mode;
            bsel_reg <= req_bsel;
         end
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign o_pc = pc_reg;
   assign o_table_page_reg = page_reg;
   assign o_busy = state_reg != psta_pkg::PSTA_ST_IDLE;
   assign o_done = state_reg == psta_pkg::PSTA_ST_DONE;
   assign o_rdata = rdata_reg;
   assign o_pm_addr = addr_reg;
   assign o_pm_cfg_space = cfg_reg;
   assign o_pm_read = read_reg;
   assign o_pm_write = write_reg;
   assign o_pm_lane_we = write_reg ? lane_reg : 3'h0;
   assign o_pm_wdata = wdata_reg;

endmodule

// >>> verif/psta_pm_model.sv
/* Program memory model: 24-bit words, one-cycle read, lane writes.
   Assumes address and space stay put while read or write is pulsed. */
`timescale 1ns/1ps
module psta_pm_model
(
   input wire logic i_clk,
   input wire logic [23:0] i_addr,
   input wire logic i_cfg,
   input wire logic i_read,
   input wire logic [2:0] i_lane_we,
   input wire logic [23:0] i_wdata,
   output logic [23:0] o_rdata
);
   logic [23:0] mem_reg [0:31];
   wire [4:0] idx = {i_cfg, i_addr[4:1]};
   always @(posedge i_clk)
   begin
      // Data is valid for one cycle only, so a late sample sees garbage
      o_rdata <= i_read ? mem_reg[idx] : ~o_rdata;
      for (int b = 0; b < 3; b++)
         if (i_lane_we[b])
            mem_reg[idx][8*b +: 8] <= i_wdata[8*b +: 8];
   end
endmodule

// >>> verif/psta_table_access_sva.sv
/* Checker for the table access block.
   Sees only the top ports; attached by the bind at the foot. */
`timescale 1ns/1ps
module psta_sva
(
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_pc_advance,
   input wire logic i_pc_load,
   input wire logic [23:0] o_pc,
   input wire logic [7:0] o_table_page_reg,
   input wire logic i_req,
   input wire logic [1:0] i_op,
   input wire logic i_byte_mode,
   input wire logic [15:0] i_eff_addr,
   input wire logic o_busy,
   input wire logic o_done,
   input wire logic [15:0] o_rdata,
   input wire logic [23:0] o_pm_addr,
   input wire logic o_pm_cfg_space,
   input wire logic o_pm_read,
   input wire logic o_pm_write,
   input wire logic [2:0] o_pm_lane_we,
   input wire logic [23:0] i_pm_rdata
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   wire logic take = i_req && !o_busy;
   wire logic rd_low = take && i_op == 2'h0;
   wire logic rd_high = take && i_op == 2'h1;
   wire logic rd_low_b1 = rd_low && i_byte_mode && i_eff_addr[0];
   wire logic rd_high_b0 = rd_high && i_byte_mode && !i_eff_addr[0];
   sequence s_take_rd;
      take && !i_op[1];
   endsequence
   sequence s_rd_walk;
      o_pm_read ##1 !o_done ##1 o_done;
   endsequence
   a_read_steps: assert property (s_take_rd |=> s_rd_walk) else $error("read walk broken");
   a_write_done: assert property (take && i_op[1] |=> o_pm_write && o_done) else $error("write late");
   a_addr_concat: assert property (take |=> o_pm_addr == $past({o_table_page_reg, i_eff_addr}))
      else $error("addr");
   a_cfg_space: assert property (take |=> o_pm_cfg_space == $past(o_table_page_reg[7]))
      else $error("space");
   a_pc_step: assert property (i_pc_advance && !i_pc_load |=> o_pc == $past(o_pc) + 24'h000002)
      else $error("pc");
   a_low_word: assert property (rd_low && !i_byte_mode |=> ##2 o_rdata == $past(i_pm_rdata[15:0]))
      else $error("low word");
   a_low_byte: assert property (rd_low_b1 |=> ##2 o_rdata == {8'h00, $past(i_pm_rdata[15:8])})
      else $error("low byte");
   a_high_word: assert property (rd_high && !i_byte_mode |=> ##2 o_rdata == {8'h00, $past(i_pm_rdata[23:16])})
      else $error("high word");
   a_high_byte: assert property (rd_high_b0 |=> ##2 o_rdata == {8'h00, $past(i_pm_rdata[23:16])})
      else $error("high byte");
   a_phantom_zero: assert property (rd_high && i_byte_mode && i_eff_addr[0] |=> ##2 o_rdata == 16'h0000)
      else $error("phantom");
   a_low_lanes: assert property (take && i_op == 2'h2 |=> o_pm_lane_we != 3'h0 && !o_pm_lane_we[2])
      else $error("upper lane");
endmodule
bind psta_table_access psta_sva i_sva (.i_clk, .i_reset_n, .i_pc_advance, .i_pc_load, .o_pc, .o_table_page_reg,
   .i_req, .i_op, .i_byte_mode, .i_eff_addr, .o_busy, .o_done, .o_rdata, .o_pm_addr, .o_pm_cfg_space,
   .o_pm_read, .o_pm_write, .o_pm_lane_we, .i_pm_rdata);

// >>> verif/psta_table_access_tb.sv
/* Testbench for the table access block.
   Assumes the memory model and the checker beside it. */
`timescale 1ns/1ps
module psta_table_access_tb;
   logic i_clk, i_reset_n, i_pc_advance, i_pc_load, i_page_write, i_req, i_byte_mode;
   logic o_busy, o_done, o_pm_cfg_space, o_pm_read, o_pm_write;
   logic [23:0] i_pc_load_value, o_pc, o_pm_addr, o_pm_wdata, i_pm_rdata;
   logic [7:0] i_page_data, o_table_page_reg;
   logic [15:0] i_eff_addr, i_wdata, o_rdata, rd;
   logic [1:0] i_op;
   logic [2:0] o_pm_lane_we, lane;
   logic [19:0] tbl [6] = '{20'h05AA5, 20'h200A5, 20'h3005A, 20'h400C3, 20'h70000, 20'h600C3};
   int error_cnt = 0;
   int n_compared = 0;
   psta_table_access i_dut (.i_clk, .i_reset_n, .i_pc_advance, .i_pc_load, .i_pc_load_value, .o_pc,
      .i_page_write, .i_page_data, .o_table_page_reg, .i_req, .i_op, .i_byte_mode, .i_eff_addr, .i_wdata,
      .o_busy, .o_done, .o_rdata, .o_pm_addr, .o_pm_cfg_space, .o_pm_read, .o_pm_write, .o_pm_lane_we,
      .o_pm_wdata, .i_pm_rdata);
   psta_pm_model i_mem (.i_clk, .i_addr(o_pm_addr), .i_cfg(o_pm_cfg_space), .i_read(o_pm_read),
      .i_lane_we(o_pm_lane_we), .i_wdata(o_pm_wdata), .o_rdata(i_pm_rdata));
   initial
   begin
      i_clk = 0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Request is held until done is sampled, then dropped one edge later
   task automatic op(input logic [1:0] o, input logic bm, input logic [15:0] ea, input logic [15:0] wd);
      int n;
      @(posedge i_clk);
      #5 {i_req, i_op, i_byte_mode, i_eff_addr, i_wdata} = {1'b1, o, bm, ea, wd};
      n = 0;
      do
      begin
         @(posedge i_clk);
         #1 n++;
      end
      while (o_done !== 1'b1 && n < 8);
      {rd, lane} = {o_rdata, o_pm_lane_we};
      if (n == 8)
      begin
         error_cnt++;
         $display("Error at %0t: done not seen, got %h expected %h", $time, o_done, 1'b1);
      end
      @(posedge i_clk);
      #5 i_req = 0;
   endtask
   task automatic set_page(input logic [7:0] pg);
      @(posedge i_clk);
      #5 {i_page_write, i_page_data} = {1'b1, pg};
      @(posedge i_clk);
      #5 i_page_write = 0;
      chk(o_table_page_reg, pg);
   endtask
   task automatic t_pc;
      @(posedge i_clk);
      #5 {i_pc_load, i_pc_advance, i_pc_load_value} = {2'b11, 24'h0000FE};
      @(posedge i_clk);
      #5 i_pc_load = 0;
      repeat (3) @(posedge i_clk);
      #5 i_pc_advance = 0;
      chk(o_pc, 24'h000104);
      $display("pc test done");
   endtask
   task automatic t_page(input logic [7:0] pg);
      set_page(pg);
      op(2'h2, 1'b0, 16'h0020, {pg, 8'h3C});
      chk({lane, o_pm_cfg_space, o_pm_addr}, {3'h3, pg[7], pg, 16'h0020});
      op(2'h0, 1'b0, 16'h0020, 16'h0000);
      chk(rd, {pg, 8'h3C});
      $display("page test done");
   endtask
   task automatic t_rw;
      set_page(8'h05);
      op(2'h0, 1'b0, 16'h0020, 16'h0000);
      chk(rd, 16'h053C);
      op(2'h3, 1'b0, 16'h0020, 16'h0011);
      chk(lane, 3'h4);
      op(2'h3, 1'b1, 16'h0020, 16'h00C3);
      chk(lane, 3'h4);
      op(2'h2, 1'b1, 16'h0020, 16'h00A5);
      chk(lane, 3'h1);
      op(2'h2, 1'b1, 16'h0021, 16'h005A);
      chk(lane, 3'h2);
      op(2'h3, 1'b1, 16'h0021, 16'h0077);
      chk(lane, 3'h0);
      for (int k = 0; k < 6; k++)
      begin
         op(tbl[k][19:18], tbl[k][17], {15'h0010, tbl[k][16]}, 16'h0000);
         chk(rd, tbl[k][15:0]);
      end
      $display("read write test done");
   endtask
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial
   begin
      {i_reset_n, i_pc_advance, i_pc_load, i_pc_load_value, i_page_write, i_page_data} = 0;
      {i_req, i_op, i_byte_mode, i_eff_addr, i_wdata} = 0;
      repeat (4) @(posedge i_clk);
      #5 i_reset_n = 1;
      chk({o_pc, o_table_page_reg}, 32'h00000000);
      t_pc;
      t_page(8'h05);
      t_page(8'h85);
      t_rw;
      stop_test;
   end
   initial
   begin
      #100us;
      error_cnt++;
      $display("Error at %0t: run did not end, got %h expected %h", $time, 1'b0, 1'b1);
      stop_test;
   end
endmodule
